// ==== hw/raid_map_pkg.sv ====
// Constants, types and helper functions shared by the stripe mapper files
package raid_map_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_DRIVES  = 6;
	localparam int NUM_ARRAYS  = 8;
	localparam int NUM_LDS     = 8;
	localparam int BLK_W       = 24;
	localparam int DATA_W      = 32;
	localparam int CAP_W       = 32;
	localparam int FIFO_DEPTH  = 32;

	// Request word layout inside the FIFO
	localparam int REQ_DATA_LSB = 0;
	localparam int REQ_BLK_LSB  = DATA_W;
	localparam int REQ_WR_BIT   = DATA_W + BLK_W;
	localparam int REQ_LD_LSB   = DATA_W + BLK_W + 1;
	localparam int REQ_W        = DATA_W + BLK_W + 1 + 3;

	// ****************************************
	// Levels and limits
	// ****************************************
	localparam logic [2:0] LEVEL_STRIPE            = 3'h0;
	localparam logic [2:0] LEVEL_MIRROR            = 3'h1;
	localparam logic [2:0] LEVEL_PARITY            = 3'h5;
	localparam logic [2:0] DRIVE_LIMIT             = 3'h6;
	localparam logic [2:0] MIN_MIRROR_DRIVES       = 3'h2;
	localparam logic [2:0] MIN_PARITY_DRIVES       = 3'h3;
	localparam logic [2:0] MIN_SPARE_PARITY_DRIVES = 3'h4;
	localparam logic [3:0] MAX_ARRAYS              = 4'h8;
	localparam logic [3:0] MAX_LDS                 = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {OP_SET_CAP, OP_CREATE_ARRAY, OP_DEFINE_LD, OP_SET_SPARE, OP_CLEAR_SPARE} cfg_op_t;
	typedef enum logic [1:0] {KIND_DATA, KIND_COPY, KIND_PARITY} op_kind_t;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [2:0] popcount6(input logic [5:0] m);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < NUM_DRIVES; i++) begin
			c = c + {2'h0, m[i]};
		end
		return c;
	endfunction : popcount6

	// Drive number of the k-th member, counted from the lowest bay
	function automatic logic [2:0] nth_member(input logic [5:0] m, input logic [2:0] k);
		logic [2:0] seen;
		logic [2:0] id;
		seen = 3'h0;
		id   = 3'h0;
		for (int i = 0; i < NUM_DRIVES; i++) begin
			if (m[i]) begin
				if (seen == k) begin
					id = 3'(i);
				end
				seen = seen + 3'h1;
			end
		end
		return id;
	endfunction : nth_member

endpackage : raid_map_pkg

// ==== hw/req_fifo.sv ====
// Request FIFO with valid and ready on both sides
module req_fifo #(
	parameter int WIDTH = 60,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
		end else if (in_valid && in_ready) begin
			wr_ptr <= wr_ptr + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ptr <= '0;
		end else if (out_valid && out_ready) begin
			rd_ptr <= rd_ptr + (AW+1)'(1);
		end
	end

endmodule : req_fifo

// ==== hw/stripe_locator.sv ====
// Block to member position and row arithmetic for each redundancy level
module stripe_locator import raid_map_pkg::*; (
	// Layout
	input  wire logic [2:0]       level,
	input  wire logic [2:0]       n,
	input  wire logic [BLK_W-1:0] blk,
	// Placement
	output logic [2:0]            data_pos,
	output logic [BLK_W-1:0]      data_row,
	output logic [2:0]            alt_pos,
	output logic [BLK_W-1:0]      alt_row,
	output logic [2:0]            col,
	output logic                  row_last
);
	always_comb begin
		logic [BLK_W-1:0] div;
		logic [BLK_W-1:0] q;
		logic [BLK_W-1:0] r;
		logic [BLK_W-1:0] t;
		logic [2:0]       ppos;
		div      = (level == LEVEL_PARITY) ? BLK_W'(n - 3'h1) : BLK_W'(n);
		if (div == '0) begin
			div = BLK_W'(1);
		end
		q        = blk / div;
		r        = blk % div;
		t        = q % BLK_W'((n == 3'h0) ? 3'h1 : n);
		ppos     = n - 3'h1 - t[2:0];
		data_pos = r[2:0];
		data_row = q;
		alt_pos  = 3'h0;
		alt_row  = q;
		col      = r[2:0];
		row_last = 1'b0;
		case (level)
			LEVEL_MIRROR: begin
				if (n == MIN_MIRROR_DRIVES) begin
					data_pos = 3'h0;
					data_row = blk;
					alt_pos  = 3'h1;
					alt_row  = blk;
				end else begin
					// Data rows even, shifted copy rows odd
					data_row = {q[BLK_W-2:0], 1'b0};
					alt_row  = {q[BLK_W-2:0], 1'b1};
					alt_pos  = (r[2:0] + 3'h1 == n) ? 3'h0 : r[2:0] + 3'h1;
				end
			end
			LEVEL_PARITY: begin
				alt_pos  = ppos;
				data_pos = (r[2:0] >= ppos) ? r[2:0] + 3'h1 : r[2:0];
				row_last = r[2:0] == n - 3'h2;
			end
			default: begin
				alt_pos = 3'h0;
			end
		endcase
	end

endmodule : stripe_locator

// ==== hw/disk_array_stripe_mapper.sv ====
// Array and logical drive mapper: configuration, request placement, failure and rebuild tracking
//
// Functional notes
// - at most eight arrays exist; a ninth create is refused.
// - only levels 0, 1 and 5 are accepted for a logical drive; on a one-drive array any level is accepted as level 0.
// - up to six bay drives may be array members.
// - array capacity uses the smallest member's capacity for every member.
// - at most eight logical drives over all arrays, each one host disk.
// - the first logical drive defined becomes the startup drive.
// - level 0 spreads consecutive blocks over all members, no redundancy.
// - an array of one drive forces level 0 on its logical drives.
// - a member failure loses only level 0 drives of that array.
// - on replacement, rebuild level 1 and 5 drives, clear the lost flag of level 0 ones.
// - level 1 needs two drives and keeps full redundancy.
// - level 1 writes each data block then a copy on another drive.
// - with one level 1 drive failed, reads and writes go to the survivor.
// - level 1 usable capacity is half the members' combined capacity.
// - level 1 over more than two drives uses the shifted copy layout.
// - shifted copy of block k lands on member (k+1) mod N.
// - two-drive level 1 keeps drive two as a full copy of drive one.
// - level 5 spreads data and parity, losing one drive of capacity.
// - level 5 with a hot spare needs at least four installed drives.
module disk_array_stripe_mapper import raid_map_pkg::*; (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Configuration commands
	input  wire logic             cfg_valid,
	input  wire cfg_op_t          cfg_op,
	input  wire logic [2:0]       cfg_array,
	input  wire logic [2:0]       cfg_ld,
	input  wire logic [2:0]       cfg_drive,
	input  wire logic [2:0]       cfg_level,
	input  wire logic [5:0]       cfg_members,
	input  wire logic [BLK_W-1:0] cfg_value,
	output logic                  cfg_done,
	output logic                  cfg_error,
	output logic [CAP_W-1:0]      cfg_result,
	// Drive bay pins
	input  wire logic [5:0]       drive_present,
	input  wire logic [5:0]       drive_fault,
	// Host requests
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire logic [2:0]       req_ld,
	input  wire logic             req_write,
	input  wire logic [BLK_W-1:0] req_block,
	input  wire logic [DATA_W-1:0] req_data,
	output logic                  req_error,
	// Drive operations
	output logic                  op_valid,
	input  wire logic             op_ready,
	output logic [2:0]            op_drive,
	output logic [BLK_W-1:0]      op_row,
	output logic                  op_write,
	output op_kind_t              op_kind,
	output logic [DATA_W-1:0]     op_data,
	// Status
	output logic [5:0]            failed_drives,
	output logic [7:0]            ld_lost,
	output logic [7:0]            rebuild_req,
	input  wire logic [7:0]       rebuild_ack,
	output logic [2:0]            boot_ld,
	output logic                  boot_valid,
	output logic [3:0]            array_count,
	output logic [3:0]            ld_count
);
	typedef enum logic [1:0] {S_IDLE, S_LOOK, S_DATA, S_ALT} state_t;

	// ****************************************
	// Tables
	// ****************************************
	logic [BLK_W-1:0] drive_cap     [NUM_DRIVES];
	logic [5:0]       array_members [NUM_ARRAYS];
	logic [2:0]       array_n       [NUM_ARRAYS];
	logic [BLK_W-1:0] array_min     [NUM_ARRAYS];
	logic [BLK_W-1:0] array_used    [NUM_ARRAYS];
	logic [7:0]       array_valid;
	logic [7:0]       ld_valid;
	logic [2:0]       ld_array      [NUM_LDS];
	logic [2:0]       ld_level      [NUM_LDS];
	logic [BLK_W-1:0] ld_base       [NUM_LDS];
	logic [CAP_W-1:0] ld_cap        [NUM_LDS];
	logic [2:0]       spare_drive;
	logic             spare_valid;

	logic [5:0]       used_mask;
	logic             parity_defined;
	logic [5:0]       present_s1, present_s2, present_d;
	logic [5:0]       fault_s1, fault_s2, fault_d;
	logic [2:0]       present_count;

	always_comb begin
		used_mask      = 6'h00;
		parity_defined = 1'b0;
		for (int i = 0; i < NUM_ARRAYS; i++) begin
			if (array_valid[i]) begin
				used_mask = used_mask | array_members[i];
			end
			if (ld_valid[i] && ld_level[i] == LEVEL_PARITY) begin
				parity_defined = 1'b1;
			end
		end
		present_count = popcount6(present_s2);
	end

	// ****************************************
	// Configuration decode
	// ****************************************
	logic             cfg_bad;
	logic [2:0]       eff_level;
	logic [BLK_W-1:0] min_cap;
	logic [CAP_W-1:0] new_cap;
	logic [2:0]       sel_n;
	logic             define_ok;

	always_comb begin
		cfg_bad   = 1'b0;
		sel_n     = array_n[cfg_array];
		eff_level = cfg_level;
		min_cap   = '1;
		new_cap   = '0;
		for (int i = 0; i < NUM_DRIVES; i++) begin
			if (cfg_members[i] && drive_cap[i] < min_cap) begin
				min_cap = drive_cap[i];
			end
		end
		case (cfg_op)
			OP_SET_CAP: begin
				cfg_bad = cfg_drive >= DRIVE_LIMIT;
			end
			OP_CREATE_ARRAY: begin
				cfg_bad = array_valid[cfg_array] || array_count >= MAX_ARRAYS || cfg_members == 6'h00 ||
					(cfg_members & used_mask) != 6'h00;
				new_cap = CAP_W'(popcount6(cfg_members)) * CAP_W'(min_cap);
			end
			OP_DEFINE_LD: begin
				if (sel_n == 3'h1) begin
					eff_level = LEVEL_STRIPE;
				end
				cfg_bad = ld_valid[cfg_ld] || ld_count >= MAX_LDS || !array_valid[cfg_array] ||
					(CAP_W'(array_used[cfg_array]) + CAP_W'(cfg_value) > CAP_W'(array_min[cfg_array]));
				case (eff_level)
					LEVEL_STRIPE: begin
						new_cap = CAP_W'(sel_n) * CAP_W'(cfg_value);
					end
					LEVEL_MIRROR: begin
						cfg_bad = cfg_bad || sel_n < MIN_MIRROR_DRIVES;
						if (sel_n == MIN_MIRROR_DRIVES) begin
							new_cap = CAP_W'(cfg_value);
						end else begin
							new_cap = CAP_W'(sel_n) * CAP_W'(cfg_value >> 1);
						end
					end
					LEVEL_PARITY: begin
						cfg_bad = cfg_bad || sel_n < MIN_PARITY_DRIVES ||
							(spare_valid && present_count < MIN_SPARE_PARITY_DRIVES);
						new_cap = CAP_W'(sel_n - 3'h1) * CAP_W'(cfg_value);
					end
					default: begin
						cfg_bad = 1'b1;
					end
				endcase
			end
			OP_SET_SPARE: begin
				cfg_bad = cfg_drive >= DRIVE_LIMIT || used_mask[cfg_drive] ||
					(parity_defined && present_count < MIN_SPARE_PARITY_DRIVES);
			end
			OP_CLEAR_SPARE: begin
				cfg_bad = 1'b0;
			end
			default: begin
				cfg_bad = 1'b1;
			end
		endcase
		define_ok = cfg_valid && cfg_op == OP_DEFINE_LD && !cfg_bad;
	end

	// ****************************************
	// Configuration tables update
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			array_valid <= 8'h00;
			ld_valid    <= 8'h00;
			array_count <= 4'h0;
			ld_count    <= 4'h0;
			spare_valid <= 1'b0;
			spare_drive <= 3'h0;
			boot_valid  <= 1'b0;
			boot_ld     <= 3'h0;
			for (int i = 0; i < NUM_ARRAYS; i++) begin
				array_members[i] <= 6'h00;
				array_n[i]       <= 3'h0;
				array_min[i]     <= '0;
				array_used[i]    <= '0;
				ld_array[i]      <= 3'h0;
				ld_level[i]      <= LEVEL_STRIPE;
				ld_base[i]       <= '0;
				ld_cap[i]        <= '0;
			end
			for (int i = 0; i < NUM_DRIVES; i++) begin
				drive_cap[i] <= '0;
			end
		end else if (cfg_valid && !cfg_bad) begin
			case (cfg_op)
				OP_SET_CAP: begin
					drive_cap[cfg_drive] <= cfg_value;
				end
				OP_CREATE_ARRAY: begin
					array_valid[cfg_array]   <= 1'b1;
					array_count              <= array_count + 4'h1;
					array_members[cfg_array] <= cfg_members;
					array_n[cfg_array]       <= popcount6(cfg_members);
					array_min[cfg_array]     <= min_cap;
					array_used[cfg_array]    <= '0;
				end
				OP_DEFINE_LD: begin
					ld_valid[cfg_ld]      <= 1'b1;
					ld_count              <= ld_count + 4'h1;
					ld_array[cfg_ld]      <= cfg_array;
					ld_level[cfg_ld]      <= eff_level;
					ld_base[cfg_ld]       <= array_used[cfg_array];
					ld_cap[cfg_ld]        <= new_cap;
					array_used[cfg_array] <= array_used[cfg_array] + cfg_value;
					if (!boot_valid) begin
						boot_valid <= 1'b1;
						boot_ld    <= cfg_ld;
					end
				end
				OP_SET_SPARE: begin
					spare_valid <= 1'b1;
					spare_drive <= cfg_drive;
				end
				default: begin
					spare_valid <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_done   <= 1'b0;
			cfg_error  <= 1'b0;
			cfg_result <= '0;
		end else begin
			cfg_done  <= cfg_valid && !cfg_bad;
			cfg_error <= cfg_valid && cfg_bad;
			if (cfg_valid) begin
				cfg_result <= new_cap;
			end
		end
	end

	// ****************************************
	// Bay pin synchronisers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			present_s1 <= 6'h00;
			present_s2 <= 6'h00;
			present_d  <= 6'h00;
			fault_s1   <= 6'h00;
			fault_s2   <= 6'h00;
			fault_d    <= 6'h00;
		end else begin
			present_s1 <= drive_present;
			present_s2 <= present_s1;
			present_d  <= present_s2;
			fault_s1   <= drive_fault;
			fault_s2   <= fault_s1;
			fault_d    <= fault_s2;
		end
	end

	// ****************************************
	// Failure and rebuild tracking
	// ****************************************
	logic [5:0] new_fail;
	logic [5:0] repaired;

	assign new_fail = ((fault_s2 & ~fault_d) | (~present_s2 & present_d)) & used_mask;
	assign repaired = present_s2 & ~present_d & failed_drives & ~new_fail;

	// New failures win over a repair, and a repair wins over an acknowledge, in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			failed_drives <= 6'h00;
			ld_lost       <= 8'h00;
			rebuild_req   <= 8'h00;
		end else begin
			failed_drives <= (failed_drives & ~repaired) | new_fail;
			for (int i = 0; i < NUM_LDS; i++) begin
				if (define_ok && cfg_ld == 3'(i)) begin
					ld_lost[i]     <= 1'b0;
					rebuild_req[i] <= 1'b0;
				end else if (ld_valid[i] && ld_level[i] == LEVEL_STRIPE) begin
					if ((array_members[ld_array[i]] & new_fail) != 6'h00) begin
						ld_lost[i] <= 1'b1;
					end else if ((array_members[ld_array[i]] & repaired) != 6'h00) begin
						ld_lost[i] <= 1'b0;
					end
				end else if (ld_valid[i]) begin
					if ((array_members[ld_array[i]] & repaired) != 6'h00) begin
						rebuild_req[i] <= 1'b1;
					end else if (rebuild_ack[i]) begin
						rebuild_req[i] <= 1'b0;
					end
				end
			end
		end
	end

	// ****************************************
	// Request FIFO
	// ****************************************
	logic             fifo_valid;
	logic             fifo_ready;
	logic [REQ_W-1:0] fifo_data;
	state_t           state, next_state;

	req_fifo #(
		.WIDTH (REQ_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   ({req_ld, req_write, req_block, req_data}),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	assign fifo_ready = state == S_IDLE;

	// ****************************************
	// Placement lookup
	// ****************************************
	logic [REQ_W-1:0]  cur;
	logic [2:0]        cur_ld;
	logic              cur_wr;
	logic [BLK_W-1:0]  cur_blk;
	logic [DATA_W-1:0] cur_data;
	logic [2:0]        cur_level;
	logic [5:0]        cur_mask;
	logic [2:0]        data_pos, alt_pos, col;
	logic [BLK_W-1:0]  data_row, alt_row;
	logic              row_last;
	logic [2:0]        d_drv, a_drv;
	logic              d_bad, a_bad, go_data, go_alt, go_fail;
	logic [DATA_W-1:0] parity_acc, next_parity;

	assign cur_ld    = cur[REQ_LD_LSB +: 3];
	assign cur_wr    = cur[REQ_WR_BIT];
	assign cur_blk   = cur[REQ_BLK_LSB +: BLK_W];
	assign cur_data  = cur[REQ_DATA_LSB +: DATA_W];
	assign cur_level = ld_level[cur_ld];
	assign cur_mask  = array_members[ld_array[cur_ld]];

	stripe_locator u_loc (
		.level    (cur_level),
		.n        (array_n[ld_array[cur_ld]]),
		.blk      (cur_blk),
		.data_pos (data_pos),
		.data_row (data_row),
		.alt_pos  (alt_pos),
		.alt_row  (alt_row),
		.col      (col),
		.row_last (row_last)
	);

	always_comb begin
		d_drv       = nth_member(cur_mask, data_pos);
		a_drv       = nth_member(cur_mask, alt_pos);
		d_bad       = failed_drives[d_drv];
		a_bad       = failed_drives[a_drv];
		next_parity = (col == 3'h0) ? cur_data : parity_acc ^ cur_data;
		go_data     = !d_bad;
		go_alt      = 1'b0;
		go_fail     = !ld_valid[cur_ld] || CAP_W'(cur_blk) >= ld_cap[cur_ld];
		case (cur_level)
			LEVEL_MIRROR: begin
				go_alt  = cur_wr ? !a_bad : (d_bad && !a_bad);
				go_fail = go_fail || (d_bad && a_bad);
			end
			LEVEL_PARITY: begin
				go_alt  = cur_wr ? (row_last && !a_bad) : (d_bad && !a_bad);
				go_fail = go_fail || (d_bad && a_bad);
			end
			default: begin
				go_fail = go_fail || d_bad || ld_lost[cur_ld];
			end
		endcase
	end

	// ****************************************
	// Request sequencer
	// ****************************************
	logic [2:0]        alt_drv_r;
	logic [BLK_W-1:0]  alt_row_r;
	op_kind_t          alt_kind_r;
	logic [DATA_W-1:0] alt_data_r;
	logic              do_alt;

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (fifo_valid) begin
					next_state = S_LOOK;
				end
			end
			S_LOOK: begin
				if (go_fail) begin
					next_state = S_IDLE;
				end else if (go_data) begin
					next_state = S_DATA;
				end else if (go_alt) begin
					next_state = S_ALT;
				end else begin
					next_state = S_IDLE;
				end
			end
			S_DATA: begin
				if (op_ready) begin
					next_state = do_alt ? S_ALT : S_IDLE;
				end
			end
			S_ALT: begin
				if (op_ready) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign op_valid = state == S_DATA || state == S_ALT;

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else if (state == S_IDLE && fifo_valid) begin
			cur <= fifo_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			parity_acc <= '0;
		end else if (state == S_LOOK && !go_fail && cur_level == LEVEL_PARITY && cur_wr) begin
			parity_acc <= next_parity;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			req_error <= 1'b0;
		end else begin
			req_error <= state == S_LOOK && go_fail;
		end
	end

	// Both legs are latched at lookup so the copy or parity leg needs no second table read
	always_ff @(posedge clk) begin
		if (rst) begin
			alt_drv_r  <= 3'h0;
			alt_row_r  <= '0;
			alt_kind_r <= KIND_DATA;
			alt_data_r <= '0;
			do_alt     <= 1'b0;
			op_drive   <= 3'h0;
			op_row     <= '0;
			op_write   <= 1'b0;
			op_kind    <= KIND_DATA;
			op_data    <= '0;
		end else if (state == S_LOOK) begin
			alt_drv_r  <= a_drv;
			alt_row_r  <= ld_base[cur_ld] + alt_row;
			alt_kind_r <= (cur_level == LEVEL_PARITY) ? KIND_PARITY : KIND_COPY;
			alt_data_r <= (cur_level == LEVEL_PARITY) ? next_parity : cur_data;
			do_alt     <= go_alt;
			op_write   <= cur_wr;
			if (go_data) begin
				op_drive <= d_drv;
				op_row   <= ld_base[cur_ld] + data_row;
				op_kind  <= KIND_DATA;
				op_data  <= cur_data;
			end else begin
				op_drive <= a_drv;
				op_row   <= ld_base[cur_ld] + alt_row;
				op_kind  <= (cur_level == LEVEL_PARITY) ? KIND_PARITY : KIND_COPY;
				op_data  <= (cur_level == LEVEL_PARITY) ? next_parity : cur_data;
			end
		end else if (state == S_DATA && op_ready && do_alt) begin
			op_drive <= alt_drv_r;
			op_row   <= alt_row_r;
			op_kind  <= alt_kind_r;
			op_data  <= alt_data_r;
		end
	end

endmodule : disk_array_stripe_mapper

// ==== testbench/disk_array_stripe_mapper_props.sv ====
// Concurrent checks on the stripe mapper ports
module disk_array_stripe_mapper_props import raid_map_pkg::*; (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Config, operations and status
	input wire logic       cfg_valid,
	input wire logic       cfg_done,
	input wire logic       cfg_error,
	input wire logic       op_valid,
	input wire logic [2:0] op_drive,
	input wire op_kind_t   op_kind,
	input wire logic [7:0] ld_lost,
	input wire logic [7:0] rebuild_req,
	input wire logic [2:0] boot_ld,
	input wire logic       boot_valid,
	input wire logic [3:0] array_count,
	input wire logic [3:0] ld_count
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_ANSWER: assert property (cfg_valid |=> cfg_done != cfg_error)
		else $error("config answer missing");
	AST_ARR_MAX: assert property (array_count <= 4'h8)
		else $error("too many arrays");
	AST_LD_MAX: assert property (ld_count <= 4'h8)
		else $error("too many logical drives");
	AST_ARR_STEP: assert property (!cfg_done |-> $stable(array_count))
		else $error("array count moved without accept");
	AST_LD_STEP: assert property (!cfg_done |-> $stable(ld_count))
		else $error("drive count moved without accept");
	AST_BOOT: assert property (boot_valid |=> boot_valid && $stable(boot_ld))
		else $error("startup drive changed");
	AST_LOST: assert property ((ld_lost & rebuild_req) == 8'h0)
		else $error("drive both lost and rebuilding");
	AST_BAY: assert property (op_valid |-> op_drive < 3'h6)
		else $error("operation to missing bay");
	AST_KIND: assert property (op_valid |-> op_kind != op_kind_t'(2'h3))
		else $error("bad operation kind");
endmodule : disk_array_stripe_mapper_props
bind disk_array_stripe_mapper disk_array_stripe_mapper_props props (.*);

// ==== testbench/drive_model.sv ====
// Drive side model: accepts operations, optionally slowly, and logs them
module drive_model import raid_map_pkg::*; (
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// Operations
	input wire logic             op_valid,
	input wire logic [2:0]       op_drive,
	input wire logic [BLK_W-1:0] op_row,
	input wire op_kind_t         op_kind,
	input wire logic             op_write,
	input wire logic [DATA_W-1:0] op_data,
	input wire logic             slow,
	output logic                 op_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [61:0] q[$];
	logic [1:0]  cnt;
	// Slow mode holds off ready for three cycles of each offer
	assign op_ready = op_valid && (!slow || cnt == 2'h3);
	always @(posedge clk) begin
		cnt <= (rst || !op_valid) ? 2'h0 : cnt + 2'h1;
		if (op_valid && op_ready) q.push_back({op_write, op_data, op_drive, op_row, op_kind});
	end
endmodule : drive_model

// ==== testbench/disk_array_stripe_mapper_tb.sv ====
// Self-checking bench for the stripe mapper
module disk_array_stripe_mapper_tb import raid_map_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, cfg_valid = 0, req_valid = 0, req_write = 0, slow = 0;
	logic cfg_done, cfg_error, req_ready, req_error, op_valid, op_ready, op_write, boot_valid;
	cfg_op_t cfg_op = OP_SET_CAP;
	op_kind_t op_kind;
	logic [2:0] cfg_array = 0, cfg_ld = 0, cfg_drive = 0, cfg_level = 0, req_ld = 0, op_drive, boot_ld;
	logic [5:0] cfg_members = 0, drive_present = 6'h0f, drive_fault = 0, failed_drives;
	logic [23:0] cfg_value = 0, req_block = 0, op_row;
	logic [31:0] cfg_result, op_data, req_data = 0;
	logic [7:0] ld_lost, rebuild_req, rebuild_ack = 0;
	logic [3:0] array_count, ld_count;
	int num_errors = 0, n_compared = 0;
	always #10 clk = ~clk;
	disk_array_stripe_mapper uut (.*);
	drive_model dm (.*);
	task automatic end_of_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cfg(input cfg_op_t o, input logic [2:0] a, l, d, v, input logic [5:0] m,
		input logic [23:0] x, input logic ok, input logic [31:0] res);
		@(negedge clk);
		{cfg_valid, cfg_op, cfg_array, cfg_ld, cfg_drive, cfg_level, cfg_members, cfg_value} = {1'b1, o, a, l, d, v, m, x};
		@(negedge clk) cfg_valid = 0;
		chk("cfg_done", ok, cfg_done);
		chk("cfg_error", !ok, cfg_error);
		if (ok && res != 0) chk("result", res, cfg_result);
	endtask : cfg
	task automatic req(input logic [2:0] l, input logic w, input logic [23:0] b);
		@(negedge clk);
		{req_valid, req_ld, req_write, req_block, req_data} = {1'b1, l, w, b, 8'ha5, b};
		@(negedge clk) req_valid = 0;
	endtask : req
	task automatic op(input logic [2:0] d, input logic [23:0] r, input logic [1:0] k,
		input logic [32:0] wd = 33'h0);
		logic [61:0] v;
		for (int i = 0; i < 50 && dm.q.size() == 0; i++) @(negedge clk);
		v = (dm.q.size() > 0) ? dm.q.pop_front() : 62'h0;
		chk("drive", d, v[28:26]);
		chk("row", r, v[25:2]);
		chk("kind", k, v[1:0]);
		chk("write", wd[32], v[61]);
		if (wd[32]) chk("data", wd[31:0], v[60:29]);
	endtask : op
	task automatic s_config();
		cfg(OP_SET_CAP, 0, 0, 0, 0, 0, 24'h64, 1, 0);
		cfg(OP_SET_CAP, 0, 0, 1, 0, 0, 24'h50, 1, 0);
		cfg(OP_SET_CAP, 0, 0, 2, 0, 0, 24'h78, 1, 0);
		cfg(OP_CREATE_ARRAY, 0, 0, 0, 0, 6'h07, 0, 1, 32'hf0);
		cfg(OP_DEFINE_LD, 0, 0, 0, 1, 0, 24'h28, 1, 32'h3c);
		chk("boot", 4'h8, {boot_valid, boot_ld});
		cfg(OP_DEFINE_LD, 0, 1, 0, 2, 0, 24'h14, 0, 0);
		cfg(OP_DEFINE_LD, 0, 1, 0, 0, 0, 24'h14, 1, 32'h3c);
		cfg(OP_SET_CAP, 0, 0, 3, 0, 0, 24'h20, 1, 0);
		cfg(OP_CREATE_ARRAY, 1, 0, 0, 0, 6'h08, 0, 1, 32'h20);
		cfg(OP_DEFINE_LD, 1, 2, 0, 1, 0, 24'h10, 1, 32'h10);
	endtask : s_config
	task automatic s_traffic();
		slow = 1;
		req(0, 1, 24'h4);
		op(1, 24'h2, KIND_DATA, {1'b1, 32'ha5000004});
		op(2, 24'h3, KIND_COPY, {1'b1, 32'ha5000004});
		slow = 0;
		req(1, 0, 24'h5);
		op(2, 24'h29, KIND_DATA);
	endtask : s_traffic
	task automatic s_failure();
		drive_fault = 6'h02;
		repeat (6) @(negedge clk);
		chk("failed", 6'h02, failed_drives);
		chk("lost", 8'h02, ld_lost);
		req(0, 0, 24'h4);
		op(2, 24'h3, KIND_COPY);
		req(1, 0, 24'h5);
		repeat (2) @(negedge clk);
		chk("req_error", 1, req_error);
		{drive_fault, drive_present} = 12'h00d;
		repeat (6) @(negedge clk) drive_present = 6'h0f;
		repeat (6) @(negedge clk);
		chk("rebuild", 8'h01, rebuild_req);
		chk("lost", 8'h00, ld_lost);
		chk("failed", 6'h00, failed_drives);
		rebuild_ack = 8'h01;
		repeat (3) @(negedge clk);
		chk("rebuild", 8'h00, rebuild_req);
	endtask : s_failure
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		s_config();
		s_traffic();
		s_failure();
		end_of_test();
	end
endmodule : disk_array_stripe_mapper_tb
